// [hw/cmp_bus_pkg.sv]
// Summary of operation
// - Bits 7:4 are read-only comparator states, bit 4+n for column n, reset zero.
// - Status bit captures comparator bus on rising second analog phase when not bypassed.
// - Latch bypass makes the status bit follow the comparator bus through the two-flop synchroniser.
// - Status reflects the comparator after the row lookup table, not raw output.
// - Bits 3:0 are read-write interrupt source selects, one per column, reset zero.
// - Select zero routes the column comparator data bit to the interrupt input.
// - Select one drives the interrupt input from falling second analog phase.
// - Two-column limited parts: selects 1:0 choose the dedicated PWM terminal count.
// - Fewer-column variants implement only bits 5:4 and 1:0, or bits 5 and 1.
package cmp_bus_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET = 8'h64;
  localparam logic [7:0] IRQ_STAT_OFFSET = 8'h68;
  localparam logic [7:0] IRQ_MASK_OFFSET = 8'h6C;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int STAT_LSB = 4;
  localparam int SEL_LSB = 0;
  localparam int NCOL = 4;
  // ---------------------------------------------------------------
  // Variants
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    VAR_FOUR = 2'b00,
    VAR_TWO = 2'b01,
    VAR_TWO_LIM = 2'b10,
    VAR_ONE = 2'b11
  } variant_t;
  typedef struct packed {
    logic [3:0] comp;
    logic [3:0] sel;
  } ctrl_t;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : cmp_bus_pkg

// [hw/cmp_column.sv]
`timescale 1ns/1ps
`default_nettype none
module cmp_column
  import cmp_bus_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Column signals, already synchronised
  input wire logic comp_lut_i,
  input wire logic phase_i,
  input wire logic bypass_i,
  input wire logic sel_i,
  input wire logic use_pwm_i,
  input wire logic pwm_tc_i,
  // Results
  output logic status_o,
  output logic irq_src_o
);
  logic latch_r;
  logic phase_d_r;
  logic fall_r;
  wire rise = phase_i && !phase_d_r;
  wire fall = !phase_i && phase_d_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_d_r <= 1'b0;
    end else begin
      phase_d_r <= phase_i;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      latch_r <= 1'b0;
    end else if (rise && !bypass_i) begin
      latch_r <= comp_lut_i;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fall_r <= 1'b0;
    end else begin
      fall_r <= fall;
    end
  end

  assign status_o = bypass_i ? comp_lut_i : latch_r;
  // Limited parts swap the phase edge for the PWM terminal count
  assign irq_src_o = !sel_i ? status_o :
                     (use_pwm_i ? pwm_tc_i : fall_r);
endmodule : cmp_column
`default_nettype wire

// [hw/cmp_bus_status.sv]
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module cmp_bus_status
  import cmp_bus_pkg::*;
#(
  parameter variant_t VARIANT = VAR_FOUR
)(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // AXI4-Lite write
  input wire logic [7:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  // AXI4-Lite read
  input wire logic [7:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  // Analog array side
  input wire logic [3:0] COMP_LUT_I,
  input wire logic [3:0] PHASE2_I,
  input wire logic [3:0] LATCH_BYPASS_I,
  input wire logic PWM_TC_I,
  // Interrupt controller side
  output logic [3:0] COL_IRQ_O,
  output logic IRQ_O
);
  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Comparator data is sampled after two flops; bypass transparency
  // is thus only as fast as the synchroniser allows.
  logic [12:0] s1_r;
  logic [12:0] s2_r;
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      s1_r <= 13'h0000;
      s2_r <= 13'h0000;
    end else begin
      s1_r <= {PWM_TC_I, LATCH_BYPASS_I, PHASE2_I, COMP_LUT_I};
      s2_r <= s1_r;
    end
  end
  wire [3:0] comp_s = s2_r[3:0];
  wire [3:0] phase_s = s2_r[7:4];
  wire [3:0] byp_s = s2_r[11:8];
  wire pwm_s = s2_r[12];

  // ---------------------------------------------------------------
  // Variant masks
  // ---------------------------------------------------------------
  logic [3:0] impl;
  always_comb begin
    unique case (VARIANT)
      VAR_FOUR: impl = 4'hF;
      VAR_TWO, VAR_TWO_LIM: impl = 4'h3;
      VAR_ONE: impl = 4'h2;
    endcase
  end
  wire use_pwm = (VARIANT == VAR_TWO_LIM);

  // ---------------------------------------------------------------
  // Columns
  // ---------------------------------------------------------------
  ctrl_t ctrl;
  logic [3:0] sel_r;
  logic [3:0] stat_raw;
  logic [3:0] src_raw;
  genvar g;
  generate
    for (g = 0; g < NCOL; g++) begin : g_col
      cmp_column u_col (
        .clk(CLK_I),
        .rst_n(RST_N_I),
        .comp_lut_i(comp_s[g]),
        .phase_i(phase_s[g]),
        .bypass_i(byp_s[g]),
        .sel_i(sel_r[g]),
        .use_pwm_i(use_pwm),
        .pwm_tc_i(pwm_s),
        .status_o(stat_raw[g]),
        .irq_src_o(src_raw[g])
      );
    end
  endgenerate
  assign ctrl.comp = stat_raw & impl;
  assign ctrl.sel = sel_r;
  assign COL_IRQ_O = src_raw & impl;

  // ---------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------
  logic aw_got_r;
  logic w_got_r;
  logic [7:0] aw_r;
  logic [7:0] wd_r;
  logic bv_r;
  assign AWREADY_O = !aw_got_r && !bv_r;
  assign WREADY_O = !w_got_r && !bv_r;
  wire aw_hs = AWVALID_I && AWREADY_O;
  wire w_hs = WVALID_I && WREADY_O;
  wire have_aw = aw_got_r || aw_hs;
  wire have_w = w_got_r || w_hs;
  wire [7:0] waddr = aw_got_r ? aw_r : AWADDR_I;
  wire [7:0] wbyte = w_got_r ? wd_r : WDATA_I[7:0];
  logic wlane_r;
  wire wlane = w_got_r ? wlane_r : WSTRB_I[0];
  wire do_wr = have_aw && have_w && !bv_r;
  wire wmapped = waddr[7:2] == CTRL_OFFSET[7:2] ||
                 waddr[7:2] == IRQ_STAT_OFFSET[7:2] ||
                 waddr[7:2] == IRQ_MASK_OFFSET[7:2];
  logic [1:0] bresp_r;

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_r <= 8'h00;
      wd_r <= 8'h00;
      wlane_r <= 1'b0;
    end else begin
      if (do_wr) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
      end else begin
        if (aw_hs) begin
          aw_got_r <= 1'b1;
          aw_r <= AWADDR_I;
        end
        if (w_hs) begin
          w_got_r <= 1'b1;
          wd_r <= WDATA_I[7:0];
          wlane_r <= WSTRB_I[0];
        end
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      bv_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (do_wr) begin
      bv_r <= 1'b1;
      bresp_r <= wmapped ? RESP_OKAY : RESP_SLVERR;
    end else if (BREADY_I) begin
      bv_r <= 1'b0;
    end
  end
  assign BVALID_O = bv_r;
  assign BRESP_O = bresp_r;

  // ---------------------------------------------------------------
  // Control and interrupt registers
  // ---------------------------------------------------------------
  wire wr_ctrl = do_wr && wlane && waddr[7:2] == CTRL_OFFSET[7:2];
  wire wr_stat = do_wr && wlane && waddr[7:2] == IRQ_STAT_OFFSET[7:2];
  wire wr_mask = do_wr && wlane && waddr[7:2] == IRQ_MASK_OFFSET[7:2];

  // Unimplemented select bits stay zero whatever software writes
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      sel_r <= CTRL_RESET[3:0];
    end else if (wr_ctrl) begin
      sel_r <= wbyte[3:0] & impl;
    end
  end

  logic [3:0] col_d_r;
  logic [3:0] ev_stat_r;
  logic [3:0] ev_mask_r;
  wire [3:0] col_rise = COL_IRQ_O & ~col_d_r;
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      col_d_r <= 4'h0;
      ev_stat_r <= 4'h0;
      ev_mask_r <= 4'h0;
    end else begin
      col_d_r <= COL_IRQ_O;
      // Set wins over a simultaneous write-one clear
      ev_stat_r <= (ev_stat_r & ~(wr_stat ? wbyte[3:0] : 4'h0)) | col_rise;
      if (wr_mask) begin
        ev_mask_r <= wbyte[3:0];
      end
    end
  end
  assign IRQ_O = |(ev_stat_r & ev_mask_r);

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------
  logic rv_r;
  logic [31:0] rd_r;
  logic [1:0] rresp_r;
  assign ARREADY_O = !rv_r;
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      rv_r <= 1'b0;
      rd_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (ARVALID_I && ARREADY_O) begin
      rv_r <= 1'b1;
      rresp_r <= RESP_OKAY;
      if (ARADDR_I[7:2] == CTRL_OFFSET[7:2]) begin
        rd_r <= {24'h000000, ctrl};
      end else if (ARADDR_I[7:2] == IRQ_STAT_OFFSET[7:2]) begin
        rd_r <= {28'h0000000, ev_stat_r};
      end else if (ARADDR_I[7:2] == IRQ_MASK_OFFSET[7:2]) begin
        rd_r <= {28'h0000000, ev_mask_r};
      end else begin
        rd_r <= 32'h0000_0000;
        rresp_r <= RESP_SLVERR;
      end
    end else if (RREADY_I) begin
      rv_r <= 1'b0;
    end
  end
  assign RVALID_O = rv_r;
  assign RDATA_O = rd_r;
  assign RRESP_O = rresp_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  chk_sel_reserved: assert property (sel_r == (sel_r & impl))
    else $error("select bit set outside variant");
  chk_sel_write: assert property (wr_ctrl |=> sel_r == ($past(wbyte[3:0]) & impl))
    else $error("select write not stored");
  chk_bypass_pass: assert property (
    (byp_s[0] && impl[0]) |-> ctrl.comp[0] == comp_s[0])
    else $error("bypass not transparent");
  chk_latch_hold: assert property (
    (!byp_s[1] && $stable(phase_s[1]) && $stable(byp_s[1]) && impl[1]) |=>
    ($stable(ctrl.comp[1]) || byp_s[1]))
    else $error("status moved without phase edge");
  chk_src_comp: assert property (!sel_r[1] |-> COL_IRQ_O[1] == ctrl.comp[1])
    else $error("comparator route wrong");
  chk_src_fall: assert property (
    (sel_r[0] && !use_pwm && impl[0] && $fell(phase_s[0]))
    |=> (COL_IRQ_O[0] || !sel_r[0]))
    else $error("falling phase not routed");
  chk_src_pwm: assert property (
    (use_pwm && sel_r[1]) |-> COL_IRQ_O[1] == pwm_s)
    else $error("pwm terminal count not routed");
  // Set must win over a clear in the same cycle
  chk_irq_level: assert property (col_rise[0] |=> ev_stat_r[0])
    else $error("event not recorded");
  chk_b_hold: assert property (BVALID_O && !BREADY_I |=> BVALID_O)
    else $error("write response dropped");
  chk_r_hold: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
    else $error("read data dropped");

  cov_write: cover property (wr_ctrl);
  cov_read: cover property (RVALID_O && RREADY_I);
  cov_bypass: cover property (byp_s[1] && $changed(ctrl.comp[1]));
  cov_irq: cover property ($rose(IRQ_O));
endmodule : cmp_bus_status
`default_nettype wire

// [verification/cmp_array_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cmp_array_model #(
  parameter int PH_HI = 6
)(
  // Clock
  input wire logic clk_i,
  // Bench control
  input wire logic [3:0] level_i,
  input wire logic fire_i,
  // Column outputs
  output logic [3:0] comp_o,
  output logic [3:0] phase_o
);
  int cnt = 0;
  // Value leaves the row lookup table one cycle after the bench sets it
  always_ff @(posedge clk_i) begin
    comp_o <= level_i;
  end
  // Phase stays low between pulses, as the column clock idles
  always_ff @(posedge clk_i) begin
    if (fire_i) begin
      cnt <= PH_HI;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  assign phase_o = (cnt > 0) ? 4'hF : 4'h0;
endmodule : cmp_array_model
`default_nettype wire

// [verification/cmp_bus_status_test.sv]
`timescale 1ns/1ps
`default_nettype none
module cmp_bus_status_test
  import cmp_bus_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals and instances
  // ---------------------------------------------------------------
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic fire = 1'h0;
  logic [3:0] level = 4'h0;
  logic [3:0] bypass = 4'h0;
  logic pwm = 1'h0;
  wire logic [3:0] col_irq2;
  wire logic [3:0] comp, phase, col_irq;
  wire logic awready, wready, bvalid, arready, rvalid, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  int miscompares = 0;
  int n_compared = 0;

  cmp_array_model model (.clk_i(clk), .level_i(level), .fire_i(fire),
    .comp_o(comp), .phase_o(phase));
  cmp_bus_status #(.VARIANT(VAR_FOUR)) dut (
    .CLK_I(clk), .RST_N_I(rst_n),
    .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
    .WDATA_I(wdata), .WSTRB_I(4'hF), .WVALID_I(wvalid), .WREADY_O(wready),
    .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
    .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
    .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
    .COMP_LUT_I(comp), .PHASE2_I(phase), .LATCH_BYPASS_I(bypass),
    .PWM_TC_I(pwm), .COL_IRQ_O(col_irq), .IRQ_O(irq));
  // Limited two-column part on the same bus, only its routing is watched
  cmp_bus_status #(.VARIANT(VAR_TWO_LIM)) dut2 (
    .CLK_I(clk), .RST_N_I(rst_n),
    .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(),
    .WDATA_I(wdata), .WSTRB_I(4'hF), .WVALID_I(wvalid), .WREADY_O(),
    .BRESP_O(), .BVALID_O(), .BREADY_I(bready),
    .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(),
    .RDATA_O(), .RRESP_O(), .RVALID_O(), .RREADY_I(rready),
    .COMP_LUT_I(comp), .PHASE2_I(phase), .LATCH_BYPASS_I(bypass),
    .PWM_TC_I(pwm), .COL_IRQ_O(col_irq2), .IRQ_O());

  initial begin
    forever #2 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    chk({30'h0, bresp}, {30'h0, RESP_OKAY});
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
    rready <= 1'h0;
  endtask : rd

  // Phase pulse, then enough cycles for the two sync stages to settle
  task automatic pulse_phase();
    @(posedge clk);
    fire <= 1'h1;
    @(posedge clk);
    fire <= 1'h0;
    tick(16);
  endtask : pulse_phase

  task automatic end_of_test();
    if (miscompares == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'h1;
    rd(CTRL_OFFSET, 32'h00, RESP_OKAY);
    wr(CTRL_OFFSET, 32'hFF);
    rd(CTRL_OFFSET, 32'h0F, RESP_OKAY);
    wr(CTRL_OFFSET, 32'h00);
    level <= 4'hA;
    tick(4);
    pulse_phase();
    rd(CTRL_OFFSET, 32'hA0, RESP_OKAY);
    chk({28'h0, col_irq}, 32'hA);
    rd(IRQ_STAT_OFFSET, 32'hA, RESP_OKAY);
    wr(IRQ_MASK_OFFSET, 32'h1);
    tick(1);
    chk({31'h0, irq}, 32'h0);
    wr(IRQ_MASK_OFFSET, 32'h8);
    tick(1);
    chk({31'h0, irq}, 32'h1);
    wr(IRQ_STAT_OFFSET, 32'h8);
    rd(IRQ_STAT_OFFSET, 32'h2, RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    // No phase edge: the latched value must hold
    level <= 4'h5;
    tick(8);
    rd(CTRL_OFFSET, 32'hA0, RESP_OKAY);
    bypass <= 4'hF;
    tick(6);
    rd(CTRL_OFFSET, 32'h50, RESP_OKAY);
    bypass <= 4'h0;
    wr(CTRL_OFFSET, 32'h0F);
    tick(8);
    pwm <= 1'h1;
    tick(4);
    chk({28'h0, col_irq2}, 32'h3);
    pwm <= 1'h0;
    tick(4);
    wr(IRQ_STAT_OFFSET, 32'hF);
    pulse_phase();
    rd(IRQ_STAT_OFFSET, 32'hF, RESP_OKAY);
    rd(8'h70, 32'h0, RESP_SLVERR);
    end_of_test();
  end

  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
endmodule : cmp_bus_status_test
`default_nettype wire
